/* src/pscls_match.sv */
`timescale 1ns/1ps
// combinational compare of one entry against one header
module pscls_match
  import pscls_pkg::*;
(
  // compare operands
  input  wire pscls_entry_t entry_in,
  input  wire pscls_hdr_t   hdr_in,
  // compare result
  output logic              hit_out
);

  function automatic logic in_rng16(input logic [15:0] v, lo, hi);
    in_rng16 = (v >= lo) && (v <= hi);
  endfunction : in_rng16

  pscls_crit_t c;
  logic [PSCLS_EN_W-1:0] ok;

  // unconfigured criteria count as matching, so any subset works
  always_comb begin
    c = entry_in.crit;
    ok[PSCLS_EN_TOS]   = in_rng16({8'h00, hdr_in.tos & c.tos_mask}, {8'h00, c.tos_lo},
                                  {8'h00, c.tos_hi});
    ok[PSCLS_EN_PROTO] = hdr_in.proto == c.proto;
    ok[PSCLS_EN_SRCIP] = (hdr_in.src_ip & c.src_mask) == (c.src_ip & c.src_mask);
    ok[PSCLS_EN_DSTIP] = (hdr_in.dst_ip & c.dst_mask) == (c.dst_ip & c.dst_mask);
    ok[PSCLS_EN_SPORT] = in_rng16(hdr_in.src_port, c.sport_lo, c.sport_hi);
    ok[PSCLS_EN_DPORT] = in_rng16(hdr_in.dst_port, c.dport_lo, c.dport_hi);
    ok[PSCLS_EN_DMAC]  = hdr_in.dst_mac == c.dst_mac;
    ok[PSCLS_EN_SMAC]  = hdr_in.src_mac == c.src_mac;
    ok[PSCLS_EN_ETYPE] = hdr_in.ethertype == c.ethertype;
    ok[PSCLS_EN_UPRI]  = (hdr_in.user_prio >= c.upri_lo) &&
                         (hdr_in.user_prio <= c.upri_hi);
    ok[PSCLS_EN_VLAN]  = hdr_in.vlan_id == c.vlan_id;
    hit_out = &(ok | ~c.en);
  end

endmodule : pscls_match

/* src/pscls_pkg.sv */
package pscls_pkg;

  // table geometry
  localparam int unsigned PSCLS_ENTRIES    = 8;
  localparam int unsigned PSCLS_IDX_W      = 3;
  localparam int unsigned PSCLS_FLOWS      = 4;
  localparam int unsigned PSCLS_FLOW_IDX_W = 2;
  localparam int unsigned PSCLS_KEY_W      = 32;
  localparam int unsigned PSCLS_USI_W      = 14;
  localparam int unsigned PSCLS_PRIO_W     = 8;
  localparam int unsigned PSCLS_REFCNT_W   = 16;
  localparam logic [15:0] PSCLS_REFCNT_MAX = 16'hFFFF;

  // enable bit positions inside the criteria mask
  localparam int unsigned PSCLS_EN_TOS   = 0;
  localparam int unsigned PSCLS_EN_PROTO = 1;
  localparam int unsigned PSCLS_EN_SRCIP = 2;
  localparam int unsigned PSCLS_EN_DSTIP = 3;
  localparam int unsigned PSCLS_EN_SPORT = 4;
  localparam int unsigned PSCLS_EN_DPORT = 5;
  localparam int unsigned PSCLS_EN_DMAC  = 6;
  localparam int unsigned PSCLS_EN_SMAC  = 7;
  localparam int unsigned PSCLS_EN_ETYPE = 8;
  localparam int unsigned PSCLS_EN_UPRI  = 9;
  localparam int unsigned PSCLS_EN_VLAN  = 10;
  localparam int unsigned PSCLS_EN_W     = 11;

  // reset values
  localparam logic [31:0] PSCLS_KEY_RST  = 32'h0000_0000;
  localparam logic [7:0]  PSCLS_PRIO_RST = 8'h00;

  typedef struct packed {
    logic [7:0]  tos;
    logic [7:0]  proto;
    logic [31:0] src_ip;
    logic [31:0] dst_ip;
    logic [15:0] src_port;
    logic [15:0] dst_port;
    logic [47:0] dst_mac;
    logic [47:0] src_mac;
    logic [15:0] ethertype;
    logic [2:0]  user_prio;
    logic [11:0] vlan_id;
  } pscls_hdr_t;

  typedef struct packed {
    logic [PSCLS_EN_W-1:0] en;
    logic [7:0]  tos_lo;
    logic [7:0]  tos_hi;
    logic [7:0]  tos_mask;
    logic [7:0]  proto;
    logic [31:0] src_ip;
    logic [31:0] src_mask;
    logic [31:0] dst_ip;
    logic [31:0] dst_mask;
    logic [15:0] sport_lo;
    logic [15:0] sport_hi;
    logic [15:0] dport_lo;
    logic [15:0] dport_hi;
    logic [47:0] dst_mac;
    logic [47:0] src_mac;
    logic [15:0] ethertype;
    logic [2:0]  upri_lo;
    logic [2:0]  upri_hi;
    logic [11:0] vlan_id;
  } pscls_crit_t;

  typedef struct packed {
    logic                    valid;
    logic                    active;
    logic                    dynamic;
    logic [PSCLS_PRIO_W-1:0] prio;
    logic [PSCLS_KEY_W-1:0]  flow_key;
    logic                    has_sup;
    logic [7:0]              sup_index;
    pscls_crit_t             crit;
  } pscls_entry_t;

  typedef struct packed {
    logic                   valid;
    logic                   active;
    logic                   upstream;
    logic [PSCLS_KEY_W-1:0] key;
    logic [PSCLS_USI_W-1:0] usi;
  } pscls_flow_t;

  // packet result toward the mac
  typedef struct packed {
    logic [PSCLS_KEY_W-1:0] flow_key;
    logic [PSCLS_USI_W-1:0] usi;
    logic                   matched;
    logic                   pre_bound;
    logic                   has_sup;
    logic [PSCLS_KEY_W-1:0] sup_key;
    logic [7:0]             sup_index;
  } pscls_result_t;

  typedef enum logic [2:0] {
    PSCLS_IDLE = 3'b001,
    PSCLS_SCAN = 3'b010,
    PSCLS_DONE = 3'b100
  } pscls_state_t;

endpackage : pscls_pkg

/* src/pscls_top.sv */
`timescale 1ns/1ps
// Overview of operation
// - each entry holds criteria, a priority and exactly one target flow.
// - entries are searched from highest priority to lowest for every packet.
// - the first entry whose every configured criterion matches selects its flow.
// - a packet matching no entry goes to the primary flow of its direction.
// - ip criteria: tos range/mask, protocol, masked addresses, port ranges.
// - link criteria: destination mac, source mac and ethertype.
// - vlan criteria: user priority range and vlan identifier.
// - an entry counts only when it and its target flow are active.
// - up to 65535 entries may reference one flow; one flow per entry.
// - flow references are 32-bit keys that uniquely name a flow.
// - each admitted upstream flow owns one unique 14-bit service index.
// - deleting a flow deletes its entries and suppression rules.
// - a match may name a suppression rule keyed by flow key and index.
// - packets already bound to a flow bypass table matching.
// - dynamic entries are readable but protected from management change.
// - the primary flow is the first flow defined for its direction.
module pscls_top
  import pscls_pkg::*;
#(
  parameter int unsigned ENTRIES = PSCLS_ENTRIES,
  parameter int unsigned FLOWS   = PSCLS_FLOWS
) (
  // clock, reset, enable
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  input  wire logic                        ce_in,
  // role: 1 = headend terminal, 0 = cable modem
  input  wire logic                        is_headend_in,
  input  wire logic                        police_up_in,
  // flow table write
  input  wire logic                        flow_wr_in,
  input  wire logic                        flow_del_in,
  input  wire logic [PSCLS_FLOW_IDX_W-1:0] flow_idx_in,
  input  wire pscls_flow_t                 flow_data_in,
  // entry write and read
  input  wire logic                        ent_wr_in,
  input  wire logic                        ent_del_in,
  input  wire logic                        ent_mgmt_in,
  input  wire logic [PSCLS_IDX_W-1:0]      ent_idx_in,
  input  wire pscls_entry_t                ent_data_in,
  output pscls_entry_t                     ent_rd_out,
  output logic                             ent_denied_out,
  output logic [PSCLS_REFCNT_W-1:0]        flow_refs_out,
  // packet in
  input  wire logic                        pkt_valid_in,
  input  wire logic                        pkt_upstream_in,
  input  wire logic                        pkt_bound_in,
  input  wire logic [PSCLS_KEY_W-1:0]      pkt_bound_key_in,
  input  wire pscls_hdr_t                  pkt_hdr_in,
  output logic                             pkt_ready_out,
  // result out
  output logic                             res_valid_out,
  output pscls_result_t                    res_out
);

  pscls_entry_t               tbl [ENTRIES];
  pscls_entry_t               next_tbl [ENTRIES];
  pscls_flow_t                flw [FLOWS];
  pscls_flow_t                next_flw [FLOWS];
  pscls_state_t               state, next_state;
  pscls_hdr_t                 hdr, next_hdr;
  logic                       up, next_up;
  logic                       bound, next_bound;
  logic [PSCLS_KEY_W-1:0]     bkey, next_bkey;
  logic [ENTRIES-1:0]         hit;
  logic [ENTRIES-1:0]         elig;
  logic                       res_valid, next_res_valid;
  pscls_result_t              res, next_res;
  pscls_entry_t               rd, next_rd;
  logic                       denied, next_denied;
  logic [PSCLS_REFCNT_W-1:0]  refs, next_refs;

  // flow key lookup; an entry of the other direction never takes part
  function automatic logic flow_active(input pscls_flow_t f [FLOWS],
                                       input logic [PSCLS_KEY_W-1:0] k,
                                       input logic d);
    flow_active = 1'b0;
    for (int i = 0; i < FLOWS; i++) begin
      if (f[i].valid && f[i].active && f[i].upstream == d && f[i].key == k) begin
        flow_active = 1'b1;
      end
    end
  endfunction : flow_active

  function automatic logic [PSCLS_USI_W-1:0] flow_usi(input pscls_flow_t f [FLOWS],
                                                      input logic [PSCLS_KEY_W-1:0] k);
    flow_usi = '0;
    for (int i = 0; i < FLOWS; i++) begin
      if (f[i].valid && f[i].upstream && f[i].key == k) flow_usi = f[i].usi;
    end
  endfunction : flow_usi

  // one comparator per entry; all compare in parallel
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : g_cmp
      pscls_match u_match (
        .entry_in (tbl[g]),
        .hdr_in   (hdr),
        .hit_out  (hit[g])
      );
      assign elig[g] = tbl[g].valid && tbl[g].active &&
                       flow_active(flw, tbl[g].flow_key, up);
    end
  endgenerate

  // table maintenance
  always_comb begin
    next_flw    = flw;
    next_tbl    = tbl;
    next_denied = 1'b0;
    next_rd     = tbl[ent_idx_in];
    next_refs   = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (tbl[i].valid && flw[flow_idx_in].valid &&
          tbl[i].flow_key == flw[flow_idx_in].key &&
          next_refs != PSCLS_REFCNT_MAX) begin
        next_refs = next_refs + 16'h0001;
      end
    end
    if (flow_wr_in) begin
      next_flw[flow_idx_in] = flow_data_in;
    end
    if (flow_del_in) begin
      next_flw[flow_idx_in] = '0;
      for (int i = 0; i < ENTRIES; i++) begin
        // suppression rule lives inside the entry, so it goes with it
        if (tbl[i].flow_key == flw[flow_idx_in].key) next_tbl[i] = '0;
      end
    end
    if (ent_wr_in || ent_del_in) begin
      if (ent_mgmt_in && tbl[ent_idx_in].valid && tbl[ent_idx_in].dynamic) begin
        next_denied = 1'b1;
      end else if (ent_del_in) begin
        next_tbl[ent_idx_in] = '0;
      end else begin
        next_tbl[ent_idx_in] = ent_data_in;
        next_tbl[ent_idx_in].dynamic = ent_data_in.dynamic && !ent_mgmt_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < ENTRIES; i++) tbl[i] <= '0;
      for (int i = 0; i < FLOWS; i++) flw[i] <= '0;
      rd     <= '0;
      denied <= 1'b0;
      refs   <= '0;
    end else if (ce_in) begin
      tbl    <= next_tbl;
      flw    <= next_flw;
      rd     <= next_rd;
      denied <= next_denied;
      refs   <= next_refs;
    end
  end

  // classifier: latch packet, pick best hit, emit result
  always_comb begin
    logic                    found;
    logic [PSCLS_PRIO_W-1:0] best_p;
    logic [PSCLS_IDX_W-1:0]  best_i;
    logic                    dir_ok;
    logic [PSCLS_KEY_W-1:0]  pkey;
    found          = 1'b0;
    best_p         = PSCLS_PRIO_RST;
    best_i         = '0;
    pkey           = PSCLS_KEY_RST;
    next_state     = state;
    next_hdr       = hdr;
    next_up        = up;
    next_bound     = bound;
    next_bkey      = bkey;
    next_res_valid = 1'b0;
    next_res       = res;
    // modem classifies upstream only, headend downstream and optionally upstream
    dir_ok = is_headend_in ? (!up || police_up_in) : up;
    case (state)
      PSCLS_IDLE: begin
        if (pkt_valid_in) begin
          next_hdr   = pkt_hdr_in;
          next_up    = pkt_upstream_in;
          next_bound = pkt_bound_in;
          next_bkey  = pkt_bound_key_in;
          next_state = PSCLS_SCAN;
        end
      end
      PSCLS_SCAN: begin
        // strict greater keeps the lowest index among equal priorities
        for (int i = 0; i < ENTRIES; i++) begin
          if (hit[i] && elig[i] && (!found || tbl[i].prio > best_p)) begin
            found  = 1'b1;
            best_p = tbl[i].prio;
            best_i = PSCLS_IDX_W'(i);
          end
        end
        found = found && dir_ok && !bound;
        // primary flow is the first valid flow of the direction
        for (int i = FLOWS - 1; i >= 0; i--) begin
          if (flw[i].valid && flw[i].upstream == up) pkey = flw[i].key;
        end
        next_res = '0;
        if (bound) begin
          next_res.flow_key  = bkey;
          next_res.pre_bound = 1'b1;
        end else if (found) begin
          next_res.flow_key  = tbl[best_i].flow_key;
          next_res.matched   = 1'b1;
          next_res.has_sup   = tbl[best_i].has_sup;
          next_res.sup_key   = tbl[best_i].flow_key;
          next_res.sup_index = tbl[best_i].sup_index;
        end else begin
          next_res.flow_key = pkey;
        end
        next_res.usi   = up ? flow_usi(flw, next_res.flow_key) : '0;
        next_res_valid = 1'b1;
        next_state     = PSCLS_DONE;
      end
      PSCLS_DONE: begin
        next_state = PSCLS_IDLE;
      end
      default: begin
        next_state = PSCLS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state     <= PSCLS_IDLE;
      hdr       <= '0;
      up        <= 1'b0;
      bound     <= 1'b0;
      bkey      <= PSCLS_KEY_RST;
      res_valid <= 1'b0;
      res       <= '0;
    end else if (ce_in) begin
      state     <= next_state;
      hdr       <= next_hdr;
      up        <= next_up;
      bound     <= next_bound;
      bkey      <= next_bkey;
      res_valid <= next_res_valid;
      res       <= next_res;
    end
  end

  // ready is registered via state, so it comes straight from a flop
  assign pkt_ready_out  = state[0];
  assign res_valid_out  = res_valid;
  assign res_out        = res;
  assign ent_rd_out     = rd;
  assign ent_denied_out = denied;
  assign flow_refs_out  = refs;

endmodule : pscls_top

/* tb/pscls_bridge_model.sv */
`timescale 1ns/1ps
// upper-layer bridge offering packets
module pscls_bridge_model
  import pscls_pkg::*;
(
  // handshake
  input  wire logic              clk_in,
  input  wire logic              ready_in,
  output logic                   valid_out,
  // packet fields
  output logic                   upstream_out,
  output logic                   bound_out,
  output logic [PSCLS_KEY_W-1:0] bound_key_out,
  output pscls_hdr_t             hdr_out
);
  // idle values at time zero
  initial begin
    valid_out = 1'b0;
    upstream_out = 1'b0;
    bound_out = 1'b0;
    bound_key_out = '0;
    hdr_out = '0;
  end
  // hold the offer until ready is seen at an edge
  task automatic send(input logic up, input logic bnd, input logic [31:0] key,
                      input logic [7:0] proto, output logic ok);
    logic r;
    ok = 1'b0;
    valid_out = 1'b1;
    upstream_out = up;
    bound_out = bnd;
    bound_key_out = key;
    hdr_out = '0;
    hdr_out.proto = proto;
    for (int i = 0; i < 20 && !ok; i++) begin
      r = ready_in;
      @(posedge clk_in);
      #1;
      ok = r;
    end
    valid_out = 1'b0;
    // released fields flip so a stale value never looks held
    upstream_out = ~up;
    bound_out = ~bnd;
    bound_key_out = ~key;
    hdr_out = ~hdr_out;
  endtask : send
endmodule : pscls_bridge_model

/* tb/pscls_checker.sv */
`timescale 1ns/1ps
// port-level checks on the flow classifier
module pscls_checker
  import pscls_pkg::*;
#(
  parameter int unsigned ENTRIES = PSCLS_ENTRIES
) (
  // clock and reset
  input wire logic                      clk_in,
  input wire logic                      rst_in,
  // table side
  input wire logic                      ce_in,
  input wire logic                      ent_wr_in,
  input wire logic                      ent_del_in,
  input wire logic                      ent_mgmt_in,
  input wire logic                      ent_denied_out,
  input wire logic [PSCLS_REFCNT_W-1:0] flow_refs_out,
  // packet side
  input wire logic                      pkt_valid_in,
  input wire logic                      pkt_bound_in,
  input wire logic [PSCLS_KEY_W-1:0]    pkt_bound_key_in,
  input wire logic                      pkt_ready_out,
  input wire logic                      res_valid_out,
  input wire pscls_result_t             res_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // packet accepted on this edge
  logic take;
  assign take = ce_in && pkt_valid_in && pkt_ready_out;
  AST_LATENCY: assert property (take |=> !pkt_ready_out
    ##1 (res_valid_out && !pkt_ready_out) ##1 pkt_ready_out) else $error("bad latency");
  AST_CAUSE: assert property (res_valid_out |-> $past(take, 2))
    else $error("result without packet");
  AST_BOUND_KEY: assert property (take && pkt_bound_in |-> ##2
    (res_out.pre_bound && res_out.flow_key == $past(pkt_bound_key_in, 2)))
    else $error("bound key lost");
  AST_BOUND_NOMATCH: assert property (res_valid_out && res_out.pre_bound
    |-> !res_out.matched) else $error("bound packet matched");
  AST_SUP_KEY: assert property (res_valid_out && res_out.has_sup
    |-> res_out.sup_key == res_out.flow_key) else $error("suppression key wrong");
  AST_SUP_HIT: assert property (res_valid_out && !res_out.matched
    |-> !res_out.has_sup) else $error("suppression without match");
  // past value is stale right after a reset edge, hence the guard
  AST_RES_HOLD: assert property (!res_valid_out && !$past(rst_in)
    |-> $stable(res_out)) else $error("result changed between packets");
  AST_DENY_CAUSE: assert property (ent_denied_out
    |-> $past(ce_in && ent_mgmt_in && (ent_wr_in || ent_del_in)))
    else $error("denial without management access");
  AST_REFS_CAP: assert property (flow_refs_out <= ENTRIES)
    else $error("reference count too large");
  // main scenarios
  cover property (take && pkt_bound_in);
  cover property (res_valid_out && res_out.matched);
  cover property (ent_denied_out);
endmodule : pscls_checker

bind pscls_top pscls_checker #(.ENTRIES(ENTRIES)) i_pscls_checker (
  .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .ent_wr_in(ent_wr_in),
  .ent_del_in(ent_del_in), .ent_mgmt_in(ent_mgmt_in), .ent_denied_out(ent_denied_out),
  .flow_refs_out(flow_refs_out), .pkt_valid_in(pkt_valid_in), .pkt_bound_in(pkt_bound_in),
  .pkt_bound_key_in(pkt_bound_key_in), .pkt_ready_out(pkt_ready_out),
  .res_valid_out(res_valid_out), .res_out(res_out));

/* tb/tb_pscls_top.sv */
`timescale 1ns/1ps
// self-checking bench for the flow classifier
module tb_pscls_top
  import pscls_pkg::*;
;
  logic                        clk_in, rst_in, ce_in, is_headend_in, police_up_in, ok;
  logic                        flow_wr_in, flow_del_in, ent_wr_in, ent_del_in, ent_mgmt_in;
  logic                        ent_denied_out, pkt_valid_in, pkt_upstream_in, pkt_bound_in;
  logic                        pkt_ready_out, res_valid_out;
  logic [PSCLS_FLOW_IDX_W-1:0] flow_idx_in;
  logic [PSCLS_IDX_W-1:0]      ent_idx_in;
  logic [PSCLS_REFCNT_W-1:0]   flow_refs_out;
  logic [PSCLS_KEY_W-1:0]      pkt_bound_key_in;
  pscls_flow_t                 flow_data_in;
  pscls_entry_t                ent_data_in, ent_rd_out, e;
  pscls_hdr_t                  pkt_hdr_in;
  pscls_result_t               res_out, res;
  int                          miscompares = 0;
  int                          compares = 0;
  // flow keys and the one service index checked
  localparam logic [31:0] KA = 32'h0000_0a01;
  localparam logic [31:0] KB = 32'h0000_0b02;
  localparam logic [31:0] KC = 32'h0000_0c03;
  localparam logic [31:0] KD = 32'h0000_0d04;
  localparam logic [13:0] UC = 14'h0123;

  pscls_top #(.ENTRIES(PSCLS_ENTRIES), .FLOWS(PSCLS_FLOWS)) i_pscls_top (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .is_headend_in(is_headend_in),
    .police_up_in(police_up_in), .flow_wr_in(flow_wr_in), .flow_del_in(flow_del_in),
    .flow_idx_in(flow_idx_in), .flow_data_in(flow_data_in), .ent_wr_in(ent_wr_in),
    .ent_del_in(ent_del_in), .ent_mgmt_in(ent_mgmt_in), .ent_idx_in(ent_idx_in),
    .ent_data_in(ent_data_in), .ent_rd_out(ent_rd_out), .ent_denied_out(ent_denied_out),
    .flow_refs_out(flow_refs_out), .pkt_valid_in(pkt_valid_in),
    .pkt_upstream_in(pkt_upstream_in), .pkt_bound_in(pkt_bound_in),
    .pkt_bound_key_in(pkt_bound_key_in), .pkt_hdr_in(pkt_hdr_in),
    .pkt_ready_out(pkt_ready_out), .res_valid_out(res_valid_out), .res_out(res_out));

  pscls_bridge_model i_pscls_bridge_model (
    .clk_in(clk_in), .ready_in(pkt_ready_out), .valid_out(pkt_valid_in),
    .upstream_out(pkt_upstream_in), .bound_out(pkt_bound_in),
    .bound_key_out(pkt_bound_key_in), .hdr_out(pkt_hdr_in));

  // 100 ns clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask : tick
  // one-cycle table strobes
  task automatic flow_op(input logic [1:0] i, input pscls_flow_t f, input logic del);
    tick(); // an edge between ops, so a strobe never drops and rises at once
    flow_idx_in = i;
    flow_data_in = f;
    flow_wr_in = !del;
    flow_del_in = del;
    tick();
    flow_wr_in = 1'b0;
    flow_del_in = 1'b0;
  endtask : flow_op
  task automatic ent_op(input logic [2:0] i, input pscls_entry_t d, input logic mg);
    tick(); // an edge between ops, so a strobe never drops and rises at once
    ent_idx_in = i;
    ent_data_in = d;
    ent_mgmt_in = mg;
    ent_wr_in = 1'b1;
    tick();
    ent_wr_in = 1'b0;
    ent_mgmt_in = 1'b0;
  endtask : ent_op
  // outputs are registered, so two edges make them settle
  task automatic peek(input logic [2:0] i, input logic [1:0] f);
    ent_idx_in = i;
    flow_idx_in = f;
    tick();
    tick();
  endtask : peek
  // offer one packet, bounded wait for its result
  task automatic pkt(input logic up, input logic bnd, input logic [31:0] bk,
                     input logic [7:0] pr, input logic [31:0] xk, input logic xm);
    i_pscls_bridge_model.send(up, bnd, bk, pr, ok);
    for (int i = 0; i < 4 && res_valid_out !== 1'b1; i++) tick();
    chk("taken", ok, 32'h0000_0001);
    chk("res_valid", res_valid_out, 32'h0000_0001);
    if (ok !== 1'b1 || res_valid_out !== 1'b1) conclude();
    res = res_out;
    chk("flow_key", res.flow_key, xk);
    chk("matched", res.matched, xm);
    tick();
  endtask : pkt
  // proto-only entry in its active, non-dynamic form
  function automatic pscls_entry_t mk(input logic [7:0] p, input logic [31:0] k,
                                      input logic [7:0] pr);
    pscls_entry_t x;
    x = '0;
    x.valid = 1'b1;
    x.active = 1'b1;
    x.prio = p;
    x.flow_key = k;
    x.crit.en[PSCLS_EN_PROTO] = 1'b1;
    x.crit.proto = pr;
    return x;
  endfunction : mk

  // main sequence
  initial begin
    {rst_in, ce_in} = 2'b11;
    {is_headend_in, police_up_in, flow_wr_in, flow_del_in} = 4'h0;
    {ent_wr_in, ent_del_in, ent_mgmt_in} = 3'b000;
    {flow_idx_in, ent_idx_in, flow_data_in, ent_data_in} = '0;
    repeat (8) @(posedge clk_in);
    #1 rst_in = 1'b0;
    chk("ready", pkt_ready_out, 32'h0000_0001);
    flow_op(2'h0, '{1'b1, 1'b1, 1'b1, KA, 14'h0001}, 1'b0);
    flow_op(2'h1, '{1'b1, 1'b1, 1'b0, KB, 14'h0000}, 1'b0);
    flow_op(2'h2, '{1'b1, 1'b1, 1'b1, KC, UC}, 1'b0);
    flow_op(2'h3, '{1'b1, 1'b1, 1'b1, KD, 14'h0004}, 1'b0);
    pkt(1'b1, 1'b0, '0, 8'h06, KA, 1'b0);
    ent_op(3'h0, mk(8'h05, KC, 8'h06), 1'b0);
    ent_op(3'h1, mk(8'h09, KD, 8'h06), 1'b0);
    ent_op(3'h2, mk(8'h09, KC, 8'h06), 1'b0);
    e = mk(8'h01, KC, 8'h11);
    e.has_sup = 1'b1;
    e.sup_index = 8'h2a;
    ent_op(3'h3, e, 1'b0);
    pkt(1'b1, 1'b0, '0, 8'h06, KD, 1'b1);
    pkt(1'b1, 1'b0, '0, 8'h11, KC, 1'b1);
    chk("usi", res.usi, UC);
    chk("sup_index", res.sup_index, 8'h2a);
    chk("sup_key", res.sup_key, KC);
    chk("has_sup", res.has_sup, 32'h0000_0001);
    pkt(1'b1, 1'b0, '0, 8'h33, KA, 1'b0);
    pkt(1'b1, 1'b1, 32'h0000_beef, 8'h06, 32'h0000_beef, 1'b0);
    chk("pre_bound", res.pre_bound, 32'h0000_0001);
    e = mk(8'h09, KD, 8'h06);
    e.active = 1'b0;
    ent_op(3'h1, e, 1'b0);
    pkt(1'b1, 1'b0, '0, 8'h06, KC, 1'b1);
    // dynamic entry refuses management change, an empty slot accepts a management write
    e = mk(8'h00, KD, 8'h32);
    e.dynamic = 1'b1;
    ent_op(3'h4, e, 1'b0);
    ent_op(3'h4, mk(8'h07, KB, 8'h32), 1'b1);
    chk("denied", ent_denied_out, 32'h0000_0001);
    ent_op(3'h5, mk(8'h02, KA, 8'h44), 1'b1);
    chk("allowed", ent_denied_out, 32'h0000_0000);
    tick();
    ent_idx_in = 3'h4;
    {ent_del_in, ent_mgmt_in} = 2'b11;
    tick();
    {ent_del_in, ent_mgmt_in} = 2'b00;
    chk("del denied", ent_denied_out, 32'h0000_0001);
    peek(3'h4, 2'h2);
    chk("dyn kept", ent_rd_out.valid, 32'h0000_0001);
    chk("dyn prio", ent_rd_out.prio, 8'h00);
    chk("refs", flow_refs_out, 32'h0000_0003);
    // management may delete an entry it owns
    tick();
    ent_idx_in = 3'h5;
    {ent_del_in, ent_mgmt_in} = 2'b11;
    tick();
    {ent_del_in, ent_mgmt_in} = 2'b00;
    chk("del allowed", ent_denied_out, 32'h0000_0000);
    peek(3'h5, 2'h0);
    chk("deleted", ent_rd_out.valid, 32'h0000_0000);
    // inactive target flow sidelines its entries, deletion cascades
    flow_op(2'h2, '{1'b1, 1'b0, 1'b1, KC, UC}, 1'b0);
    pkt(1'b1, 1'b0, '0, 8'h11, KA, 1'b0);
    flow_op(2'h2, '0, 1'b1);
    peek(3'h0, 2'h2);
    chk("entry gone", ent_rd_out.valid, 32'h0000_0000);
    chk("refs gone", flow_refs_out, 32'h0000_0000);
    // headend role: downstream primary, upstream only when policing
    is_headend_in = 1'b1;
    ent_op(3'h1, mk(8'h09, KD, 8'h06), 1'b0);
    pkt(1'b0, 1'b0, '0, 8'h06, KB, 1'b0);
    pkt(1'b1, 1'b0, '0, 8'h06, KA, 1'b0);
    police_up_in = 1'b1;
    pkt(1'b1, 1'b0, '0, 8'h06, KD, 1'b1);
    // link and user-priority criteria each veto a higher-priority entry, a matching vlan id lets it win
    e = mk(8'h0f, KA, 8'h06);
    e.crit.en[PSCLS_EN_ETYPE] = 1'b1;
    e.crit.ethertype = 16'h0800;
    ent_op(3'h6, e, 1'b0);
    pkt(1'b1, 1'b0, '0, 8'h06, KD, 1'b1);
    e = mk(8'h0f, KA, 8'h06);
    e.crit.en[PSCLS_EN_UPRI] = 1'b1;
    e.crit.upri_lo = 3'h1;
    e.crit.upri_hi = 3'h3;
    ent_op(3'h6, e, 1'b0);
    pkt(1'b1, 1'b0, '0, 8'h06, KD, 1'b1);
    e.crit.upri_lo = 3'h0;
    e.crit.en[PSCLS_EN_VLAN] = 1'b1;
    ent_op(3'h6, e, 1'b0);
    pkt(1'b1, 1'b0, '0, 8'h06, KA, 1'b1);
    conclude();
  end
endmodule : tb_pscls_top
